// ### src/odc_pkg.sv
package odc_pkg;

  // Register map, printed offsets used as addresses
  localparam int ODC_ADDR_W = 8;
  localparam int ODC_REG_W = 16;
  localparam logic [7:0] ODC_ADDR_CH6_INT = 8'h10;
  localparam logic [7:0] ODC_ADDR_CH6_FLO = 8'h11;
  localparam logic [7:0] ODC_ADDR_CH7_CTL = 8'h12;
  localparam logic [7:0] ODC_ADDR_CH7_INT = 8'h13;
  localparam logic [7:0] ODC_ADDR_CH7_FLO = 8'h14;
  localparam logic [15:0] ODC_REG_RESET = 16'h0000;
  localparam logic [15:0] ODC_INT_MASK = 16'h0FFF;
  localparam logic [15:0] ODC_CTL_MASK = 16'h1FDF;
  localparam logic [15:0] ODC_FLO_MASK = 16'hFFFF;

  ////////////////////////////////////////////////////////////////////////////
  // Field layout
  localparam int ODC_INT_W = 8;
  localparam int ODC_FRAC_W = 20;
  localparam int ODC_FHI_W = 4;
  localparam int ODC_INT_LSB = 4;
  localparam int ODC_FHI_LSB = 0;
  localparam int ODC_CTL_SUPPLY = 0;
  localparam int ODC_CTL_STATE_LSB = 1;
  localparam int ODC_CTL_DRV_LSB = 3;
  localparam int ODC_CTL_POS = 6;
  localparam int ODC_CTL_NEG = 7;
  localparam int ODC_CTL_SLEW = 8;
  localparam int ODC_CTL_FON = 9;
  localparam int ODC_CTL_PRE_LSB = 10;
  localparam int ODC_CNT_W = 9;

  // Prescaler codes and terminal counts
  localparam logic [2:0] ODC_PRE_DIV2 = 3'h0;
  localparam logic [2:0] ODC_PRE_DIV3 = 3'h1;
  localparam logic [2:0] ODC_PRE_DIV1 = 3'h7;
  localparam logic [1:0] ODC_PRE_LAST1 = 2'h0;
  localparam logic [1:0] ODC_PRE_LAST2 = 2'h1;
  localparam logic [1:0] ODC_PRE_LAST3 = 2'h2;

  typedef enum logic [1:0] {ODC_DRV_LVDS, ODC_DRV_LVCMOS, ODC_DRV_HCSL} odc_drv_e;
  typedef enum logic [1:0] {ODC_OUT_OFF, ODC_OUT_ON, ODC_OUT_LOW, ODC_OUT_HIGH} odc_state_e;

  typedef struct packed {
    logic [ODC_INT_W-1:0] int_div;
    logic [ODC_FRAC_W-1:0] frac;
    logic frac_on;
    logic [2:0] prescaler;
  } odc_div_cfg_s;

endpackage

// ### src/odc_output_divider_config.sv
`timescale 1ns/10ps
`default_nettype none
module odc_output_divider_config
  import odc_pkg::*;
#(
  parameter int ADDR_W = ODC_ADDR_W
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // Configuration port
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [ODC_REG_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [ODC_REG_W-1:0] reg_rdata_out,
  // Channel 6 settings held elsewhere
  input wire logic ch6_fraction_on_in,
  input wire logic [2:0] ch6_fraction_prescaler_in,
  // Divided clock enables, channel 6 then 7
  output logic ch6_tick_out,
  output logic ch7_tick_out,
  // Channel 7 output stage
  output logic ch7_edge_rate_slow_out,
  output logic ch7_positive_side_on_out,
  output logic ch7_negative_side_on_out,
  output odc_drv_e ch7_driver_type_out,
  output odc_state_e ch7_output_state_out,
  output logic ch7_supply_level_out
);

  if (ADDR_W < ODC_ADDR_W) begin : g_addr_w_check
    $error("ADDR_W too narrow for the register map");
  end

  function automatic logic [1:0] odc_pre_last(input logic [2:0] code, input logic on);
    logic [1:0] r;
    r = ODC_PRE_LAST1;
    if (on) begin
      case (code)
        ODC_PRE_DIV2: r = ODC_PRE_LAST2;
        ODC_PRE_DIV3: r = ODC_PRE_LAST3;
        default: r = ODC_PRE_LAST1;
      endcase
    end
    return r;
  endfunction

  function automatic logic odc_hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    return a == ADDR_W'(off);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  logic [ODC_REG_W-1:0] stage_q [2];
  logic [ODC_REG_W-1:0] stage_d [2];
  logic [ODC_REG_W-1:0] int_q [2];
  logic [ODC_REG_W-1:0] int_d [2];
  logic [ODC_REG_W-1:0] flo_q [2];
  logic [ODC_REG_W-1:0] flo_d [2];
  logic [ODC_REG_W-1:0] ctl7_q, ctl7_d;
  logic [ODC_REG_W-1:0] rdata_q, rdata_d;
  logic wr_flo [2];
  logic wr_int [2];
  logic wr_ctl;

  always_comb begin
    wr_int[0] = reg_wr_in && odc_hit(reg_addr_in, ODC_ADDR_CH6_INT);
    wr_int[1] = reg_wr_in && odc_hit(reg_addr_in, ODC_ADDR_CH7_INT);
    wr_flo[0] = reg_wr_in && odc_hit(reg_addr_in, ODC_ADDR_CH6_FLO);
    wr_flo[1] = reg_wr_in && odc_hit(reg_addr_in, ODC_ADDR_CH7_FLO);
    wr_ctl = reg_wr_in && odc_hit(reg_addr_in, ODC_ADDR_CH7_CTL);
    ctl7_d = wr_ctl ? (reg_wdata_in & ODC_CTL_MASK) : ctl7_q;
    for (int c = 0; c < 2; c++) begin
      stage_d[c] = wr_int[c] ? (reg_wdata_in & ODC_INT_MASK) : stage_q[c];
      // Integer and high fraction go live together with the low fraction
      int_d[c] = wr_flo[c] ? stage_q[c] : int_q[c];
      flo_d[c] = wr_flo[c] ? reg_wdata_in : flo_q[c];
    end
    rdata_d = rdata_q;
    if (reg_rd_in) begin
      rdata_d = '0;
      if (odc_hit(reg_addr_in, ODC_ADDR_CH6_INT)) rdata_d = stage_q[0];
      if (odc_hit(reg_addr_in, ODC_ADDR_CH6_FLO)) rdata_d = flo_q[0];
      if (odc_hit(reg_addr_in, ODC_ADDR_CH7_CTL)) rdata_d = ctl7_q;
      if (odc_hit(reg_addr_in, ODC_ADDR_CH7_INT)) rdata_d = stage_q[1];
      if (odc_hit(reg_addr_in, ODC_ADDR_CH7_FLO)) rdata_d = flo_q[1];
    end
  end

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      for (int c = 0; c < 2; c++) begin
        stage_q[c] <= ODC_REG_RESET;
        int_q[c] <= ODC_REG_RESET;
        flo_q[c] <= ODC_REG_RESET;
      end
      ctl7_q <= ODC_REG_RESET;
      rdata_q <= ODC_REG_RESET;
    end else begin
      for (int c = 0; c < 2; c++) begin
        stage_q[c] <= stage_d[c];
        int_q[c] <= int_d[c];
        flo_q[c] <= flo_d[c];
      end
      ctl7_q <= ctl7_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_out = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Channel 7 output stage controls
  assign ch7_edge_rate_slow_out = ctl7_q[ODC_CTL_SLEW];
  assign ch7_positive_side_on_out = ctl7_q[ODC_CTL_POS];
  assign ch7_negative_side_on_out = ctl7_q[ODC_CTL_NEG] && ctl7_q[ODC_CTL_POS];
  assign ch7_supply_level_out = ctl7_q[ODC_CTL_SUPPLY];

  always_comb begin
    case (ctl7_q[ODC_CTL_DRV_LSB +: 2])
      2'h2: ch7_driver_type_out = ODC_DRV_LVCMOS;
      2'h3: ch7_driver_type_out = ODC_DRV_HCSL;
      default: ch7_driver_type_out = ODC_DRV_LVDS;
    endcase
    case (ctl7_q[ODC_CTL_STATE_LSB +: 2])
      2'h1: ch7_output_state_out = ODC_OUT_ON;
      2'h2: ch7_output_state_out = ODC_OUT_LOW;
      2'h3: ch7_output_state_out = ODC_OUT_HIGH;
      default: ch7_output_state_out = ODC_OUT_OFF;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fractional dividers: prescaler, then integer count stretched by carry
  odc_div_cfg_s cfg [2];
  logic [1:0] pre_cnt_q [2];
  logic [1:0] pre_cnt_d [2];
  logic [ODC_CNT_W-1:0] div_cnt_q [2];
  logic [ODC_CNT_W-1:0] div_cnt_d [2];
  logic [ODC_FRAC_W-1:0] acc_q [2];
  logic [ODC_FRAC_W-1:0] acc_d [2];
  logic extra_q [2];
  logic extra_d [2];
  logic tick_q [2];
  logic tick_d [2];
  logic pre_tick [2];
  logic [ODC_CNT_W-1:0] last [2];
  logic [ODC_FRAC_W:0] sum [2];

  always_comb begin
    for (int c = 0; c < 2; c++) begin
      cfg[c].int_div = int_q[c][ODC_INT_LSB +: ODC_INT_W];
      cfg[c].frac = {int_q[c][ODC_FHI_LSB +: ODC_FHI_W], flo_q[c]};
    end
    cfg[0].frac_on = ch6_fraction_on_in;
    cfg[0].prescaler = ch6_fraction_prescaler_in;
    cfg[1].frac_on = ctl7_q[ODC_CTL_FON];
    cfg[1].prescaler = ctl7_q[ODC_CTL_PRE_LSB +: 3];
    for (int c = 0; c < 2; c++) begin
      // Bypass when fraction is off, else 2, 3 or 1
      pre_tick[c] = pre_cnt_q[c] >= odc_pre_last(cfg[c].prescaler, cfg[c].frac_on);
      pre_cnt_d[c] = pre_tick[c] ? '0 : pre_cnt_q[c] + 2'h1;
      last[c] = {1'b0, cfg[c].int_div} + ODC_CNT_W'(extra_q[c]);
      sum[c] = {1'b0, acc_q[c]} + {1'b0, cfg[c].frac};
      div_cnt_d[c] = div_cnt_q[c];
      acc_d[c] = acc_q[c];
      extra_d[c] = extra_q[c];
      tick_d[c] = 1'b0;
      if (pre_tick[c]) begin
        if (div_cnt_q[c] >= last[c]) begin
          div_cnt_d[c] = '0;
          tick_d[c] = 1'b1;
          acc_d[c] = cfg[c].frac_on ? sum[c][ODC_FRAC_W-1:0] : '0;
          extra_d[c] = cfg[c].frac_on && sum[c][ODC_FRAC_W];
        end else begin
          div_cnt_d[c] = div_cnt_q[c] + ODC_CNT_W'(1);
        end
      end
    end
  end

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      for (int c = 0; c < 2; c++) begin
        pre_cnt_q[c] <= '0;
        div_cnt_q[c] <= '0;
        acc_q[c] <= '0;
        extra_q[c] <= 1'b0;
        tick_q[c] <= 1'b0;
      end
    end else begin
      for (int c = 0; c < 2; c++) begin
        pre_cnt_q[c] <= pre_cnt_d[c];
        div_cnt_q[c] <= div_cnt_d[c];
        acc_q[c] <= acc_d[c];
        extra_q[c] <= extra_d[c];
        tick_q[c] <= tick_d[c];
      end
    end
  end

  assign ch6_tick_out = tick_q[0];
  assign ch7_tick_out = tick_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic p7_tick, p6_tick, fon7, div3_7;
  logic [ODC_CNT_W-1:0] gap7_q;
  logic stable7_q;
  logic cfg7_chg;
  logic cfg7_chg_q;
  assign p7_tick = pre_tick[1];
  assign p6_tick = pre_tick[0];
  assign fon7 = cfg[1].frac_on;
  assign div3_7 = fon7 && (cfg[1].prescaler == ODC_PRE_DIV3);
  assign cfg7_chg = wr_flo[1] || wr_ctl;

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      gap7_q <= '0;
      stable7_q <= 1'b0;
      cfg7_chg_q <= 1'b0;
    end else begin
      gap7_q <= tick_q[1] ? '0 : gap7_q + ODC_CNT_W'(1);
      // A tick launched in the write cycle still carries the old setting
      stable7_q <= (cfg7_chg || cfg7_chg_q) ? 1'b0 : (tick_q[1] ? 1'b1 : stable7_q);
      cfg7_chg_q <= cfg7_chg;
    end
  end

  sequence s_div3_start;
    p7_tick && div3_7;
  endsequence

  sequence s_div3_hold;
    div3_7 [*3];
  endsequence

  AST_NEG_NEEDS_POS: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    wr_ctl && reg_wdata_in[ODC_CTL_NEG] && !reg_wdata_in[ODC_CTL_POS] |=> !ch7_negative_side_on_out)
    else $error("negative side on without positive side");

  AST_CH7_BYPASS: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    !fon7 ##1 !fon7 |-> p7_tick)
    else $error("channel 7 prescaler not bypassed");

  AST_CH6_BYPASS: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    !ch6_fraction_on_in ##1 !ch6_fraction_on_in |-> p6_tick)
    else $error("channel 6 prescaler not bypassed");

  AST_DIV3: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    s_div3_start ##1 s_div3_hold |-> p7_tick && !$past(p7_tick) && !$past(p7_tick, 2))
    else $error("divide by three prescaler period wrong");

  AST_INT_PERIOD: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    tick_q[1] && stable7_q && !fon7 |-> gap7_q == {1'b0, cfg[1].int_div})
    else $error("integer period not value plus one");

  AST_ZERO_FRAC: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    tick_q[1] && stable7_q && (cfg[1].frac == '0) |-> !extra_q[1])
    else $error("stretch without fraction");

  AST_COMMIT: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    !$stable(cfg[1].int_div) || !$stable(cfg[1].frac) |-> $past(wr_flo[1]))
    else $error("divider setting changed without low fraction write");

  AST_FRAC_ASSEMBLY: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    wr_flo[1] |=> cfg[1].frac == {$past(stage_q[1][ODC_FHI_W-1:0]), $past(reg_wdata_in)})
    else $error("fraction not assembled from both registers");

  AST_STATE_LOW: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    wr_ctl && reg_wdata_in[ODC_CTL_STATE_LSB +: 2] == 2'h2 |=> ch7_output_state_out == ODC_OUT_LOW)
    else $error("static low state not selected");

  AST_DRV_LVDS: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    wr_ctl && !reg_wdata_in[ODC_CTL_DRV_LSB + 1] |=> ch7_driver_type_out == ODC_DRV_LVDS)
    else $error("LVDS driver not selected");

  AST_RSVD_READ: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    reg_rd_in && odc_hit(reg_addr_in, ODC_ADDR_CH7_CTL) |=> (reg_rdata_out & ~ODC_CTL_MASK) == '0)
    else $error("reserved control bits read nonzero");

  AST_CTL_BITS: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    wr_ctl |=> fon7 == $past(reg_wdata_in[ODC_CTL_FON]) && ch7_edge_rate_slow_out == $past(reg_wdata_in[ODC_CTL_SLEW])
      && ch7_supply_level_out == $past(reg_wdata_in[ODC_CTL_SUPPLY]))
    else $error("control bit not applied");

endmodule
`default_nettype wire

// ### tb/odc_output_divider_config_tb.sv
`timescale 1ns/10ps
`default_nettype none
module odc_output_divider_config_tb;
  import odc_pkg::*;
  typedef struct {logic [15:0] d; logic [7:0] o;} odc_row_s;
  logic ref_clk = 1'b0, reset_in = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, rv;
  logic ch6_on = 1'b0, ch6_tick, ch7_tick, slow, pos, neg, sup;
  logic [2:0] ch6_pre = 3'h0;
  odc_drv_e drv;
  odc_state_e st;
  int fails = 0, n_tests = 0, c;
  odc_row_s rows[8] = '{'{16'h0001, 8'b0_0_0_00_00_1}, '{16'h000A, 8'b0_0_0_00_01_0},
    '{16'h0014, 8'b0_0_0_01_10_0}, '{16'h001E, 8'b0_0_0_10_11_0}, '{16'h0080, 8'b0_0_0_00_00_0},
    '{16'h00C0, 8'b0_1_1_00_00_0}, '{16'h0140, 8'b1_1_0_00_00_0}, '{16'hFFFF, 8'b1_1_1_10_11_1}};
  logic [2:0] codes[3] = '{3'h0, 3'h1, 3'h7};
  int facs[3] = '{2, 3, 1};

  always #10 ref_clk = ~ref_clk;

  odc_output_divider_config i_dut (.ref_clk_in(ref_clk), .reset_in(reset_in), .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata),
    .ch6_fraction_on_in(ch6_on), .ch6_fraction_prescaler_in(ch6_pre), .ch6_tick_out(ch6_tick),
    .ch7_tick_out(ch7_tick), .ch7_edge_rate_slow_out(slow), .ch7_positive_side_on_out(pos),
    .ch7_negative_side_on_out(neg), .ch7_driver_type_out(drv), .ch7_output_state_out(st),
    .ch7_supply_level_out(sup));

  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("tests %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask

  task automatic set_div(input logic [7:0] base, input logic [7:0] n, input logic [19:0] f);
    wr(base, {4'h0, n, f[19:16]});
    wr(base + 8'h01, f[15:0]);
  endtask

  // Skips two ticks so that a short period after a change is not counted
  task automatic meas(input bit ch7, input int k, output int cyc);
    int n;
    int g;
    n = 0;
    g = 0;
    cyc = 0;
    while (n < k + 2 && g < 4000) begin
      @(negedge ref_clk);
      g++;
      cyc++;
      if ((ch7 ? ch7_tick : ch6_tick) === 1'b1) begin
        n++;
        if (n == 2) cyc = 0;
      end
    end
    if (n < k + 2) begin
      fails++;
      $display("mismatch at %0t: tick timeout", $time);
      results();
    end
  endtask

  task automatic chk_reset();
    chk({8'h00, slow, pos, neg, drv, st, sup}, 16'h0000, "outputs after reset");
    for (int a = 16; a < 22; a++) begin
      rd(8'(a), rv);
      chk(rv, 16'h0000, "register after reset");
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(negedge ref_clk);
    reset_in = 1'b0;
    chk_reset();
    $display("test reset done");
    foreach (rows[i]) begin
      wr(ODC_ADDR_CH7_CTL, rows[i].d);
      chk({8'h00, slow, pos, neg, drv, st, sup}, {8'h00, rows[i].o}, "ch7 outputs");
      rd(ODC_ADDR_CH7_CTL, rv);
      chk(rv, rows[i].d & 16'h1FDF, "ch7 control readback");
    end
    $display("test control rows done");
    wr(ODC_ADDR_CH7_INT, 16'hFFFF);
    rd(ODC_ADDR_CH7_INT, rv);
    chk(rv, 16'h0FFF, "integer register reserved bits");
    wr(8'h15, 16'hFFFF);
    rd(8'h15, rv);
    chk(rv, 16'h0000, "unmapped address");
    wr(ODC_ADDR_CH7_CTL, 16'h0000);
    set_div(ODC_ADDR_CH7_INT, 8'd2, 20'h0);
    meas(1'b1, 2, c);
    chk(16'(c), 16'(2 * 3), "ch7 integer period, prescaler bypassed");
    wr(ODC_ADDR_CH7_INT, 16'h0050);
    meas(1'b1, 2, c);
    chk(16'(c), 16'(2 * 3), "ch7 period before low write");
    wr(ODC_ADDR_CH7_FLO, 16'h0000);
    meas(1'b1, 2, c);
    chk(16'(c), 16'(2 * 6), "ch7 period after low write");
    set_div(ODC_ADDR_CH7_INT, 8'd2, 20'h0);
    for (int i = 0; i < 3; i++) begin
      wr(ODC_ADDR_CH7_CTL, {3'h0, codes[i], 10'h200});
      meas(1'b1, 1, c);
      chk(16'(c), 16'(facs[i] * 3), "ch7 prescaled period");
    end
    $display("test ch7 integer divider done");
    set_div(ODC_ADDR_CH7_INT, 8'd2, 20'h8_0000);
    meas(1'b1, 2, c);
    chk(16'(c), 16'(2 * 3 + 1), "ch7 half fraction");
    set_div(ODC_ADDR_CH7_INT, 8'd2, 20'h0_8000);
    meas(1'b1, 32, c);
    chk(16'(c), 16'(32 * 3 + 1), "ch7 low fraction");
    wr(ODC_ADDR_CH7_CTL, 16'h0000);
    meas(1'b1, 2, c);
    chk(16'(c), 16'(2 * 3), "ch7 fraction off");
    $display("test ch7 fraction done");
    @(negedge ref_clk);
    ch6_pre = 3'h1;
    set_div(ODC_ADDR_CH6_INT, 8'd4, 20'h0);
    meas(1'b0, 2, c);
    chk(16'(c), 16'(2 * 5), "ch6 period, prescaler bypassed");
    @(negedge ref_clk);
    ch6_on = 1'b1;
    meas(1'b0, 1, c);
    chk(16'(c), 16'(3 * 5), "ch6 prescaled period");
    set_div(ODC_ADDR_CH6_INT, 8'd4, 20'h8_0000);
    ch6_pre = 3'h7;
    meas(1'b0, 2, c);
    chk(16'(c), 16'(2 * 5 + 1), "ch6 half fraction");
    $display("test ch6 divider done");
    wr(ODC_ADDR_CH7_CTL, 16'h01DF);
    @(negedge ref_clk);
    reset_in = 1'b1;
    @(negedge ref_clk);
    reset_in = 1'b0;
    chk_reset();
    $display("test mid-run reset done");
    results();
  end
endmodule
`default_nettype wire
